// ===== dv/pin_channel_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module pin_channel_asserts (
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic       config_reset_n,
  input wire logic       read,
  input wire logic       write,
  input wire logic       waitrequest,
  input wire logic [1:0] pin_low_leak,
  input wire logic [1:0] upper_above,
  input wire logic [1:0] lower_above,
  input wire logic [3:0] drv_mode,
  input wire logic [1:0] clamp_enable,
  input wire logic [1:0] upper_compare_out,
  input wire logic [1:0] lower_compare_out,
  input wire logic [1:0] comparator_low_leak,
  input wire logic [1:0] load_on,
  input wire logic [1:0] load_low_leak,
  input wire logic [5:0] range_code,
  input wire logic [1:0] measure_hiz,
  input wire logic [3:0] output_impedance_trim,
  input wire logic [2:0] comparator_deadband_code,
  input wire logic [2:0] droop_comp_code
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // The past-reset guard skips the first edge, where outputs still hold reset values.
  a_clamp_receive: assert property (
    clamp_enable == {drv_mode[3:2] == 2'h2, drv_mode[1:0] == 2'h2})
    else $error("clamp enable differs from receive mode");
  a_pin_leak_ch0: assert property (
    !$past(reset) && !$past(pin_low_leak[0]) |-> load_low_leak[0] && !load_on[0]
    && drv_mode[1:0] == 2'h0 && measure_hiz[0] && comparator_low_leak[0])
    else $error("channel 0 not in low leak");
  a_pin_leak_ch1: assert property (
    !$past(reset) && !$past(pin_low_leak[1]) |-> load_low_leak[1] && drv_mode[3:2] == 2'h0
    && measure_hiz[1] && comparator_low_leak[1])
    else $error("channel 1 not in low leak");
  a_leak_not_on: assert property ((load_on & load_low_leak) == 2'h0)
    else $error("load on while in low leak");
  a_range_no_a: assert property (
    !$past(reset) && !$past(pin_low_leak[0]) |-> range_code[2:0] != 3'h4)
    else $error("range A while pin low leak");
  a_range_codes: assert property (range_code[2:0] <= 3'h4 && range_code[5:3] <= 3'h4)
    else $error("range code out of set");
  a_pair_forced: assert property (
    !$past(reset) && (upper_compare_out[1] != $past(upper_above[1])
    || lower_compare_out[1] != $past(lower_above[1])) |-> upper_compare_out[1] && lower_compare_out[1])
    else $error("channel 1 compare neither own nor forced high");
  a_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("bus answer not one cycle");
  a_cfg_defaults: assert property (!config_reset_n |-> ##2 (output_impedance_trim == 4'h8
    && comparator_deadband_code == 3'h0 && droop_comp_code == 3'h0))
    else $error("config reset did not restore defaults");
endmodule // pin_channel_asserts
bind pin_channel_control_decode pin_channel_asserts i_chk (.*);
`default_nettype wire

// ===== dv/pin_channel_control_decode_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "pin_channel_regs.vh"
module pin_channel_control_decode_bench;
  logic        ref_clk, reset, config_reset_n, read, write, waitrequest;
  logic [2:0]  address;
  logic [31:0] writedata, readdata, rd, v;
  logic [11:0] stim;
  logic [1:0]  data_in, receive_select, pin_low_leak, upper_above, lower_above;
  logic        diff_upper_above, diff_lower_above, ll, on;
  logic [1:0]  drive_data, clamp_enable, upper_compare_out, lower_compare_out;
  logic [1:0]  comparator_low_leak, load_on, load_low_leak, measure_hiz, e1, e2, m;
  logic [3:0]  drv_mode, output_impedance_trim;
  logic [5:0]  range_code;
  logic [2:0]  comparator_deadband_code, droop_comp_code, r0, r1;
  int          errors, comparisons, cycles, i, j;

  pin_channel_control_decode i_dut (.*);
  tester_pattern_model i_tester (.*);

  initial begin
    ref_clk = 0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic stop_test;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // A hang in the bus wait is cut here; the full run needs about 1100 cycles.
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      stop_test;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // ----------------------------------------
  // Avalon master
  // ----------------------------------------
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    do @(posedge ref_clk); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 0;
    write <= 0;
  endtask

  task automatic apply(input logic [11:0] s);
    @(posedge ref_clk);
    stim <= s;
    @(posedge ref_clk);
    #1;
  endtask

  initial begin
    reset = 1;
    config_reset_n = 1;
    read = 0;
    write = 0;
    address = 0;
    writedata = 0;
    stim = 12'h030;
    errors = 0;
    comparisons = 0;
    repeat (4) @(posedge ref_clk);
    reset <= 0;
    bus(0, `REG_TRIM, 0); chk(rd, 32'h8);
    bus(0, `REG_ROUTE, 0); chk(rd, 32'h0);
    for (i = 0; i < 16; i++) begin
      v = {22'h0, ~i[2:0], i[2:0], i[3:0]};
      bus(1, `REG_TRIM, v);
      bus(0, `REG_TRIM, 0); chk(rd, v);
      apply(12'h030);
      chk({droop_comp_code, comparator_deadband_code, output_impedance_trim}, v);
    end
    for (i = 0; i < 8; i++) begin
      bus(1, `REG_ROUTE, i);
      for (j = 0; j < 4; j++) begin
        e1[0] = j[0] ^ i[0];
        e1[1] = (i[2] ? j[0] : j[1]) ^ i[1];
        apply(12'h030 | j); chk(drive_data, e1);
        chk(drv_mode, 4'h5);
      end
    end
    for (i = 0; i < 128; i++) begin
      if (i % 64 == 0) bus(1, `REG_ROUTE, (i / 64) << 3);
      e1 = i[6] ? {1'b1, i[4]} : i[1:0];
      e2 = i[6] ? {1'b1, i[5]} : i[3:2];
      apply({i[5:0], 6'h30}); chk({upper_compare_out, lower_compare_out}, {e1, e2});
    end
    bus(1, `REG_ROUTE, 0);
    for (i = 0; i < 64; i++) begin
      bus(1, `REG_LOAD, {i[4], 1'b0, i[1], 1'b0, i[3], 1'b0, i[2]});
      ll = i[4] | !i[5];
      on = !ll && !i[2] && (i[3] || (i[0] && !i[1]));
      m = ll ? 2'h0 : !i[0] ? 2'h1 : i[1] ? 2'h3 : 2'h2;
      apply({7'h1, i[5], 1'b0, i[0], 2'h0});
      chk({load_on[0], load_low_leak[0]}, {on, ll});
      chk({drv_mode[1:0], clamp_enable[0]}, {m, m == 2'h2});
      chk({comparator_low_leak[0], measure_hiz[0]}, {!i[5], 1'b1});
    end
    for (i = 0; i < 32; i++) begin
      bus(1, `REG_RANGE, {i[2:0], i[2:0]});
      bus(1, `REG_LOAD, {1'b1, i[3], 8'h0});
      r0 = i[2] ? (i[3] && i[4] ? 3'h4 : 3'h3) : i[2:0];
      r1 = i[2] ? 3'h4 : i[2:0];
      apply({7'h1, i[4], 4'h0}); chk(range_code, {r1, r0});
      chk(measure_hiz[0], !(i[3] && i[4]));
    end
    bus(1, 3'h5, 32'hF);
    bus(0, 3'h5, 0); chk(rd, 32'h0);
    bus(1, `REG_TRIM, 32'h3);
    bus(1, `REG_STATUS, 32'hFFFFFFFF);
    // Both channels drive data and force in range A; status must show exactly that.
    bus(0, `REG_STATUS, 0); chk(rd, 32'h00245000);
    @(posedge ref_clk);
    config_reset_n <= 0;
    @(posedge ref_clk);
    config_reset_n <= 1;
    apply(12'h030); chk(output_impedance_trim, 4'h8);
    bus(0, `REG_RANGE, 0); chk(rd, 32'h0);
    stop_test;
  end
endmodule // pin_channel_control_decode_bench
`default_nettype wire

// ===== dv/tester_pattern_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Tester timing side
// ----------------------------------------
// One pattern word fans out to every channel pin, so the bench changes all at one edge.
module tester_pattern_model (
  input  wire logic [11:0] stim,
  output logic [1:0]       data_in,
  output logic [1:0]       receive_select,
  output logic [1:0]       pin_low_leak,
  output logic [1:0]       upper_above,
  output logic [1:0]       lower_above,
  output logic             diff_upper_above,
  output logic             diff_lower_above
);
  assign {diff_lower_above, diff_upper_above, lower_above, upper_above, pin_low_leak,
          receive_select, data_in} = stim;
endmodule // tester_pattern_model
`default_nettype wire

// ===== shared/pin_channel_regs.vh
`ifndef PIN_CHANNEL_REGS_VH
`define PIN_CHANNEL_REGS_VH

// ----------------------------------------
// Register word indices (Avalon word address)
// ----------------------------------------
`define ADDR_W            3
`define REG_ROUTE         3'h0
`define REG_TRIM          3'h1
`define REG_LOAD          3'h2
`define REG_RANGE         3'h3
`define REG_STATUS        3'h4

// ----------------------------------------
// Route register fields
// ----------------------------------------
`define FLIP_LSB          0
`define PAIR_DRV_BIT      2
`define PAIR_CMP_BIT      3
`define ROUTE_RST         4'h0

// ----------------------------------------
// Trim register fields
// ----------------------------------------
`define IMP_LSB           0
`define IMP_MSB           3
`define DEADBAND_LSB      4
`define DEADBAND_MSB      6
`define DROOP_LSB         7
`define DROOP_MSB         9
`define IMP_RST           4'h8
`define DEADBAND_RST      3'h0
`define DROOP_RST         3'h0

// ----------------------------------------
// Load register fields, one bit per channel
// ----------------------------------------
`define LOAD_OFF_LSB      0
`define DIAG_LSB          2
`define TERM_LSB          4
`define SLEAK_LSB         6
`define FORCE_LSB         8
`define LOAD_RST          10'h000

// ----------------------------------------
// Range register fields
// ----------------------------------------
`define RANGE_RST         6'h00
`define RSEL_HI_BIT       2

// ----------------------------------------
// Decoded codes
// ----------------------------------------
`define DRV_LOW_LEAK      2'h0
`define DRV_DATA          2'h1
`define DRV_RECEIVE       2'h2
`define DRV_TERM          2'h3
`define RANGE_E           3'h0
`define RANGE_D           3'h1
`define RANGE_C           3'h2
`define RANGE_B           3'h3
`define RANGE_A           3'h4

`endif

// ===== verilog/channel_decode.v
`timescale 1ns/1ps
`default_nettype none
`include "pin_channel_regs.vh"

module channel_decode (
  input  wire       receive_select,
  input  wire       termination_choose,
  input  wire       serial_low_leak,
  input  wire       pin_low_leak,
  input  wire       load_off,
  input  wire       load_diag_on,
  input  wire       measure_unit_force_on,
  input  wire [2:0] current_range_select,
  output reg  [1:0] drv_mode,
  output wire       clamp_enable,
  output reg        load_on,
  output wire       load_low_leak,
  output reg  [2:0] range_code,
  output wire       measure_hiz
);

  wire leak = serial_low_leak | ~pin_low_leak;

  assign load_low_leak = leak;
  assign measure_hiz   = ~pin_low_leak | (~measure_unit_force_on);
  assign clamp_enable  = (drv_mode == `DRV_RECEIVE);

  always @* begin
    if (leak) begin
      drv_mode = `DRV_LOW_LEAK;
    end else if (!receive_select) begin
      drv_mode = `DRV_DATA;
    end else if (termination_choose) begin
      drv_mode = `DRV_TERM;
    end else begin
      drv_mode = `DRV_RECEIVE;
    end
  end

  always @* begin
    if (leak) begin
      load_on = 1'b0;
    end else if (load_off) begin
      load_on = 1'b0;
    end else if (load_diag_on) begin
      load_on = 1'b1;
    end else begin
      load_on = receive_select & ~termination_choose;
    end
  end

  always @* begin
    case (current_range_select)
      3'h0: range_code = `RANGE_E;
      3'h1: range_code = `RANGE_D;
      3'h2: range_code = `RANGE_C;
      3'h3: range_code = `RANGE_B;
      default: begin
        // Range A is only safe while the measure unit really forces.
        if (measure_unit_force_on && pin_low_leak) begin
          range_code = `RANGE_A;
        end else begin
          range_code = `RANGE_B;
        end
      end
    endcase
  end

endmodule // channel_decode

`default_nettype wire

// ===== verilog/pin_channel_control_decode.v
// How it works
// - A 4-bit impedance trim steps driver resistance by 0.36 ohm, 1000 nominal and default.
// - A per-channel flip bit inverts that channel's data after driver selection, reset 0.
// - Paired drive makes both drivers take channel 0 data, reset 0.
// - Paired drive plus inversion yields complementary outputs from channel 0 data.
// - Driver clamps are on exactly when the driver is in high-impedance receive.
// - Without paired compare each channel reports its own upper and lower threshold tests.
// - Paired compare puts the pin-difference results on channel 0 outputs.
// - Paired compare forces both channel 1 compare outputs high.
// - A 3-bit deadband code sets hysteresis for both modes, reset 000.
// - One droop code drives both driver and comparator droop compensation.
// - Serial low-leak 1 or pin low-leak 0 puts the load in low leak above all else.
// - Outside low leak, load off wins, then diagnostic on turns the load on.
// - Otherwise the load is on only for receive 1 with termination choice 0.
// - The range code serves force and measure, with A falling back to B when not forcing.
// - Range codes 000 to 011 give E, D, C, B; 1xx gives A only when forcing and pin low-leak is 1.
// - Pin low-leak 0 forces driver, comparator and load to low leak and the unit to hiz.
//
// Register access over Avalon-MM and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pin_channel_regs.vh"

module pin_channel_control_decode (
  input  wire               ref_clk,
  input  wire               reset,
  input  wire               config_reset_n,
  // Avalon-MM slave.
  input  wire [`ADDR_W-1:0] address,
  input  wire               read,
  input  wire               write,
  input  wire [31:0]        writedata,
  output reg  [31:0]        readdata,
  output reg                waitrequest,
  // Tester timing side.
  input  wire [1:0]         data_in,
  input  wire [1:0]         receive_select,
  input  wire [1:0]         pin_low_leak,
  input  wire [1:0]         upper_above,
  input  wire [1:0]         lower_above,
  input  wire               diff_upper_above,
  input  wire               diff_lower_above,
  output reg  [1:0]         drive_data,
  output reg  [3:0]         drv_mode,
  output reg  [1:0]         clamp_enable,
  output reg  [1:0]         upper_compare_out,
  output reg  [1:0]         lower_compare_out,
  output reg  [1:0]         comparator_low_leak,
  output reg  [1:0]         load_on,
  output reg  [1:0]         load_low_leak,
  output reg  [5:0]         range_code,
  output reg  [1:0]         measure_hiz,
  output reg  [3:0]         output_impedance_trim,
  output reg  [2:0]         comparator_deadband_code,
  output reg  [2:0]         droop_comp_code
);

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  reg  [3:0] route_reg;
  reg  [3:0] imp_reg;
  reg  [2:0] deadband_reg;
  reg  [2:0] droop_reg;
  reg  [9:0] load_reg;
  reg  [5:0] range_reg;

  wire [1:0] data_flip             = route_reg[`FLIP_LSB+1:`FLIP_LSB];
  wire       paired_drive_enable   = route_reg[`PAIR_DRV_BIT];
  wire       paired_compare_enable = route_reg[`PAIR_CMP_BIT];
  wire [1:0] load_off              = load_reg[`LOAD_OFF_LSB+1:`LOAD_OFF_LSB];
  wire [1:0] load_diag_on          = load_reg[`DIAG_LSB+1:`DIAG_LSB];
  wire [1:0] termination_choose    = load_reg[`TERM_LSB+1:`TERM_LSB];
  wire [1:0] serial_low_leak       = load_reg[`SLEAK_LSB+1:`SLEAK_LSB];
  wire [1:0] measure_unit_force_on = load_reg[`FORCE_LSB+1:`FORCE_LSB];

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  // Every access waits exactly one cycle, which gives the read mux a full
  // cycle and keeps readdata a clean flop output.
  wire req        = read | write;
  wire write_take = write & ~waitrequest;

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      waitrequest <= 1'b1;
    end else if (req && waitrequest) begin
      waitrequest <= 1'b0;
    end else begin
      waitrequest <= 1'b1;
    end
  end

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      route_reg    <= `ROUTE_RST;
      imp_reg      <= `IMP_RST;
      deadband_reg <= `DEADBAND_RST;
      droop_reg    <= `DROOP_RST;
      load_reg     <= `LOAD_RST;
      range_reg    <= `RANGE_RST;
    end else if (!config_reset_n) begin
      // The reset pin restores the same defaults as power-up.
      route_reg    <= `ROUTE_RST;
      imp_reg      <= `IMP_RST;
      deadband_reg <= `DEADBAND_RST;
      droop_reg    <= `DROOP_RST;
      load_reg     <= `LOAD_RST;
      range_reg    <= `RANGE_RST;
    end else if (write_take) begin
      if (address == `REG_ROUTE) begin
        route_reg <= writedata[3:0];
      end else if (address == `REG_TRIM) begin
        imp_reg      <= writedata[`IMP_MSB:`IMP_LSB];
        deadband_reg <= writedata[`DEADBAND_MSB:`DEADBAND_LSB];
        droop_reg    <= writedata[`DROOP_MSB:`DROOP_LSB];
      end else if (address == `REG_LOAD) begin
        load_reg <= writedata[9:0];
      end else if (address == `REG_RANGE) begin
        range_reg <= writedata[5:0];
      end
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  reg [31:0] read_next;

  always @* begin
    read_next = 32'h00000000;
    if (address == `REG_ROUTE) begin
      read_next[3:0] = route_reg;
    end else if (address == `REG_TRIM) begin
      read_next[9:0] = {droop_reg, deadband_reg, imp_reg};
    end else if (address == `REG_LOAD) begin
      read_next[9:0] = load_reg;
    end else if (address == `REG_RANGE) begin
      read_next[5:0] = range_reg;
    end else if (address == `REG_STATUS) begin
      read_next[1:0]   = upper_compare_out;
      read_next[3:2]   = lower_compare_out;
      read_next[5:4]   = load_on;
      read_next[7:6]   = load_low_leak;
      read_next[9:8]   = clamp_enable;
      read_next[11:10] = measure_hiz;
      read_next[15:12] = drv_mode;
      read_next[21:16] = range_code;
    end
  end

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      readdata <= 32'h00000000;
    end else if (read && waitrequest) begin
      readdata <= read_next;
    end
  end

  // ----------------------------------------
  // Drive data routing
  // ----------------------------------------
  reg [1:0] drive_next;
  integer   i;

  always @* begin
    drive_next = 2'h0;
    for (i = 0; i < 2; i = i + 1) begin
      // Flip follows routing, so paired drive with one flip gives a
      // complementary pair from channel 0 data.
      drive_next[i] = (paired_drive_enable ? data_in[0] : data_in[i])
                      ^ data_flip[i];
    end
  end

  // ----------------------------------------
  // Comparator output routing
  // ----------------------------------------
  reg [1:0] upper_next;
  reg [1:0] lower_next;

  always @* begin
    if (paired_compare_enable) begin
      upper_next = {1'b1, diff_upper_above};
      lower_next = {1'b1, diff_lower_above};
    end else begin
      upper_next = upper_above;
      lower_next = lower_above;
    end
  end

  // ----------------------------------------
  // Per-channel decode
  // ----------------------------------------
  wire [3:0] mode_w;
  wire [1:0] clamp_w;
  wire [1:0] load_on_w;
  wire [1:0] load_ll_w;
  wire [5:0] range_w;
  wire [1:0] hiz_w;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : chan
      channel_decode u_dec (
        .receive_select        (receive_select[g]),
        .termination_choose    (termination_choose[g]),
        .serial_low_leak       (serial_low_leak[g]),
        .pin_low_leak          (pin_low_leak[g]),
        .load_off              (load_off[g]),
        .load_diag_on          (load_diag_on[g]),
        .measure_unit_force_on (measure_unit_force_on[g]),
        .current_range_select  (range_reg[3*g+2:3*g]),
        .drv_mode              (mode_w[2*g+1:2*g]),
        .clamp_enable          (clamp_w[g]),
        .load_on               (load_on_w[g]),
        .load_low_leak         (load_ll_w[g]),
        .range_code            (range_w[3*g+2:3*g]),
        .measure_hiz           (hiz_w[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // Output flops
  // ----------------------------------------
  // All outputs carry one cycle of latency; the timing side must treat
  // them as registered decode, not as the analog fast path.
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      drive_data               <= 2'h0;
      drv_mode                 <= 4'h0;
      clamp_enable             <= 2'h0;
      upper_compare_out        <= 2'h0;
      lower_compare_out        <= 2'h0;
      comparator_low_leak      <= 2'h3;
      load_on                  <= 2'h0;
      load_low_leak            <= 2'h3;
      range_code               <= 6'h00;
      measure_hiz              <= 2'h3;
      output_impedance_trim    <= `IMP_RST;
      comparator_deadband_code <= `DEADBAND_RST;
      droop_comp_code          <= `DROOP_RST;
    end else begin
      drive_data               <= drive_next;
      drv_mode                 <= mode_w;
      clamp_enable             <= clamp_w;
      upper_compare_out        <= upper_next;
      lower_compare_out        <= lower_next;
      comparator_low_leak      <= ~pin_low_leak;
      load_on                  <= load_on_w;
      load_low_leak            <= load_ll_w;
      range_code               <= range_w;
      measure_hiz              <= hiz_w;
      output_impedance_trim    <= imp_reg;
      comparator_deadband_code <= deadband_reg;
      droop_comp_code          <= droop_reg;
    end
  end

endmodule // pin_channel_control_decode

`default_nettype wire
